//--- hw/pulse_setup_pkg.sv
package pulse_setup_pkg;

  // Clock and time base
  localparam int CLK_HZ = 20_000_000;
  localparam int MS_PER_S = 1000;
  localparam int MS_CYCLES_DEF = CLK_HZ / MS_PER_S;
  localparam int POWERUP_TIME_MS = 2000;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_RESOLUTION = 8'h04;
  localparam logic [7:0] OFS_ACCEL = 8'h08;
  localparam logic [7:0] OFS_SETTLE = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_MASK = 8'h14;
  localparam logic [7:0] OFS_STATE = 8'h18;
  localparam logic [7:0] OFS_POSITION = 8'h1C;
  localparam logic [7:0] OFS_CONTROL = 8'h20;

  // Event bits in status and mask
  localparam int EV_W = 4;
  localparam int EV_VALID = 0;
  localparam int EV_ALARM = 1;
  localparam int EV_INPOS = 2;
  localparam int EV_SERVO = 3;

  // Control bits
  localparam int CTL_ALARM_CLR = 0;

  // Selector fields and reset values
  localparam logic [3:0] SEL_DEFAULT = 4'h0;
  localparam int SEL_RES_LSB = 0;
  localparam int SEL_TYPE_BIT = 3;
  localparam int SEL_POL_BIT = 2;
  localparam int SMOOTH_LAST = 7;
  localparam int FAULT_N = 3;
  localparam int POS_W = 16;
  localparam int MS_W = 11;

  // Resolution per revolution
  function automatic logic [13:0] resolution(input logic [1:0] code);
    unique case (code)
      2'h0: resolution = 14'd1000;
      2'h1: resolution = 14'd2500;
      2'h2: resolution = 14'd5000;
      2'h3: resolution = 14'd10000;
    endcase
  endfunction : resolution

  // Acceleration time in ms per smoothing step
  function automatic logic [7:0] accel_ms(input logic [2:0] code);
    unique case (code)
      3'h0: accel_ms = 8'd45;
      3'h1: accel_ms = 8'd50;
      3'h2: accel_ms = 8'd60;
      3'h3: accel_ms = 8'd65;
      3'h4: accel_ms = 8'd70;
      3'h5: accel_ms = 8'd80;
      3'h6: accel_ms = 8'd85;
      3'h7: accel_ms = 8'd170;
    endcase
  endfunction : accel_ms

  // Shortest settling time in ms per smoothing step
  function automatic logic [10:0] settle_ms(input logic [2:0] code);
    unique case (code)
      3'h0: settle_ms = 11'd100;
      3'h1: settle_ms = 11'd110;
      3'h2: settle_ms = 11'd130;
      3'h3: settle_ms = 11'd150;
      3'h4: settle_ms = 11'd170;
      3'h5: settle_ms = 11'd200;
      3'h6: settle_ms = 11'd250;
      3'h7: settle_ms = 11'd500;
    endcase
  endfunction : settle_ms

endpackage : pulse_setup_pkg

//--- hw/step_decode.sv
`timescale 1ns/10ps
`default_nettype none
// Turns the two command pins into forward and reverse step pulses
module step_decode (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Format: 0 two pulse lines, 1 step plus direction; 1 active low
  input wire logic step_dir_mode,
  input wire logic active_low,
  // Command pins
  input wire logic pin_a,
  input wire logic pin_b,
  // One-cycle step pulses
  output var logic fwd_step,
  output var logic rev_step
);

  logic act_a;
  logic act_b;
  logic prev_a_r;
  logic prev_b_r;
  logic edge_a;
  logic edge_b;

  // Apply the selected polarity to both pins
  assign act_a = pin_a ^ active_low;
  assign act_b = pin_b ^ active_low;
  assign edge_a = act_a & ~prev_a_r;
  assign edge_b = act_b & ~prev_b_r;

  // Remember the last active levels; start as active so no false edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      prev_a_r <= 1'b1;
      prev_b_r <= 1'b1;
    end
    else
    begin
      prev_a_r <= act_a;
      prev_b_r <= act_b;
    end
  end

  // Pulse pair, or step pin with direction level on the second pin
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fwd_step <= 1'b0;
      rev_step <= 1'b0;
    end
    else if (step_dir_mode)
    begin
      fwd_step <= edge_a & act_b;
      rev_step <= edge_a & ~act_b;
    end
    else
    begin
      fwd_step <= edge_a;
      rev_step <= edge_b;
    end
  end

endmodule : step_decode
`default_nettype wire

//--- hw/pulse_command_input_setup.sv
// Our own choices: the plain strobed port and the register offsets.
`timescale 1ns/10ps
`default_nettype none
module pulse_command_input_setup #(
  parameter int MS_CYCLES = pulse_setup_pkg::MS_CYCLES_DEF,
  parameter int POWERUP_MS = pulse_setup_pkg::POWERUP_TIME_MS
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Front-panel selectors
  input wire logic [3:0] pulse_sel,
  input wire logic [3:0] smoothing_selector,
  // Command and sequence inputs
  input wire logic forward_pulse_input,
  input wire logic reverse_pulse_input,
  input wire logic run_cmd,
  input wire logic [pulse_setup_pkg::FAULT_N-1:0] fault_detect,
  // Register bus
  input wire logic [pulse_setup_pkg::ADDR_W-1:0] addr,
  input wire logic [pulse_setup_pkg::DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output var logic [pulse_setup_pkg::DATA_W-1:0] rdata,
  // Status outputs
  output var logic fault_output,
  output var logic indicator_orange,
  output var logic indicator_green,
  output var logic [pulse_setup_pkg::FAULT_N-1:0] fault_indicators,
  output var logic servo_on,
  output var logic fwd_step,
  output var logic rev_step,
  output var logic in_position,
  output var logic irq
);

  localparam int PRE_W = 16;
  localparam int EV_W = pulse_setup_pkg::EV_W;
  localparam int MS_W = pulse_setup_pkg::MS_W;
  localparam int POS_W = pulse_setup_pkg::POS_W;
  localparam int FAULT_N_L = pulse_setup_pkg::FAULT_N;

  // Elaboration checks
  if (MS_CYCLES < 1 || MS_CYCLES >= (1 << PRE_W))
  begin : g_bad_ms
    $error("MS_CYCLES out of range");
  end
  if (POWERUP_MS < 1 || POWERUP_MS >= (1 << MS_W))
  begin : g_bad_pu
    $error("POWERUP_MS out of range");
  end

  typedef enum logic [1:0] {
    PWR_SAMPLE = 2'b00,
    PWR_WAIT = 2'b01,
    PWR_READY = 2'b10
  } pwr_state_type;

  pwr_state_type pwr_r;
  logic [3:0] pulse_cfg_r;
  logic [2:0] smooth_cfg_r;
  logic smooth_bad_r;
  logic [PRE_W-1:0] pre_r;
  logic ms_tick_r;
  logic [MS_W-1:0] pu_ms_r;
  logic [MS_W-1:0] settle_cnt_r;
  logic [FAULT_N_L-1:0] fault_lamp_r;
  logic run_armed_r;
  logic servo_r;
  logic fault_out_r;
  logic orange_r;
  logic green_r;
  logic fwd_r;
  logic rev_r;
  logic inpos_r;
  logic [POS_W-1:0] pos_r;
  logic [EV_W-1:0] status_r;
  logic [EV_W-1:0] mask_r;
  logic irq_r;
  logic [pulse_setup_pkg::DATA_W-1:0] rdata_r;
  logic dec_fwd;
  logic dec_rev;
  logic alarm;
  logic alarm_clr;
  logic servo_nxt;
  logic [EV_W-1:0] ev;
  logic [pulse_setup_pkg::DATA_W-1:0] rdata_nxt;

  // Step decoding with the captured format
  step_decode u_dec (
    .clk(clk),
    .arst_n(arst_n),
    .step_dir_mode(pulse_cfg_r[pulse_setup_pkg::SEL_TYPE_BIT]),
    .active_low(pulse_cfg_r[pulse_setup_pkg::SEL_POL_BIT]),
    .pin_a(forward_pulse_input),
    .pin_b(reverse_pulse_input),
    .fwd_step(dec_fwd),
    .rev_step(dec_rev)
  );

  // Power-up sequence: capture selectors, then wait for fault output
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pwr_r <= PWR_SAMPLE;
      pulse_cfg_r <= pulse_setup_pkg::SEL_DEFAULT;
      smooth_cfg_r <= 3'h0;
      smooth_bad_r <= 1'b0;
      pu_ms_r <= '0;
    end
    else
    begin
      unique case (pwr_r)
        PWR_SAMPLE:
        begin
          pulse_cfg_r <= pulse_sel;
          smooth_cfg_r <= smoothing_selector[2:0];
          if (smoothing_selector > 4'(pulse_setup_pkg::SMOOTH_LAST))
          begin
            smooth_cfg_r <= 3'h0;
            smooth_bad_r <= 1'b1;
          end
          pwr_r <= PWR_WAIT;
        end
        PWR_WAIT:
        begin
          if (ms_tick_r)
          begin
            pu_ms_r <= pu_ms_r + 1'b1;
            if (pu_ms_r == MS_W'(POWERUP_MS - 1))
            begin
              pwr_r <= PWR_READY;
            end
          end
        end
        PWR_READY:
        begin
          pwr_r <= PWR_READY;
        end
        default:
        begin
          pwr_r <= PWR_SAMPLE;
        end
      endcase
    end
  end

  // Millisecond time base
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pre_r <= '0;
      ms_tick_r <= 1'b0;
    end
    else if (pre_r == PRE_W'(MS_CYCLES - 1))
    begin
      pre_r <= '0;
      ms_tick_r <= 1'b1;
    end
    else
    begin
      pre_r <= pre_r + 1'b1;
      ms_tick_r <= 1'b0;
    end
  end

  // Fault lamps latch each cause; clear needs the cause gone
  assign alarm_clr = wr_stb && addr == pulse_setup_pkg::OFS_CONTROL &&
                     wdata[pulse_setup_pkg::CTL_ALARM_CLR];
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fault_lamp_r <= '0;
    end
    else if (alarm_clr)
    begin
      fault_lamp_r <= fault_detect;
    end
    else
    begin
      fault_lamp_r <= fault_lamp_r | fault_detect;
    end
  end
  assign alarm = |fault_lamp_r;

  // Run must be seen low once before the motor may be energised
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_armed_r <= 1'b0;
    end
    else if (pwr_r == PWR_READY && !run_cmd)
    begin
      run_armed_r <= 1'b1;
    end
  end

  // Motor energise, lamps and fault output
  assign servo_nxt = run_cmd && run_armed_r && !alarm &&
                     pwr_r == PWR_READY;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      servo_r <= 1'b0;
      fault_out_r <= 1'b0;
      orange_r <= 1'b0;
      green_r <= 1'b0;
    end
    else
    begin
      servo_r <= servo_nxt;
      fault_out_r <= pwr_r == PWR_READY && !alarm;
      orange_r <= pwr_r == PWR_READY && !alarm && !servo_nxt;
      green_r <= servo_nxt;
    end
  end

  // Steps reach the output only while energised; position follows
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      fwd_r <= 1'b0;
      rev_r <= 1'b0;
      pos_r <= '0;
    end
    else
    begin
      fwd_r <= dec_fwd && servo_r;
      rev_r <= dec_rev && servo_r;
      if (dec_fwd && servo_r)
      begin
        pos_r <= pos_r + 1'b1;
      end
      else if (dec_rev && servo_r)
      begin
        pos_r <= pos_r - 1'b1;
      end
    end
  end

  // Settling timer restarts on each step
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      settle_cnt_r <= '0;
      inpos_r <= 1'b0;
    end
    else if (!servo_r || dec_fwd || dec_rev)
    begin
      settle_cnt_r <= '0;
      inpos_r <= 1'b0;
    end
    else if (!inpos_r && ms_tick_r)
    begin
      settle_cnt_r <= settle_cnt_r + 1'b1;
      if (settle_cnt_r ==
          pulse_setup_pkg::settle_ms(smooth_cfg_r) - 1'b1)
      begin
        inpos_r <= 1'b1;
      end
    end
  end

  // Events: ready, alarm, in position, energised
  assign ev[pulse_setup_pkg::EV_VALID] =
    pwr_r == PWR_WAIT && ms_tick_r && pu_ms_r == MS_W'(POWERUP_MS - 1);
  assign ev[pulse_setup_pkg::EV_ALARM] = |(fault_detect & ~fault_lamp_r);
  assign ev[pulse_setup_pkg::EV_INPOS] = inpos_r == 1'b0 && servo_r &&
    !dec_fwd && !dec_rev && ms_tick_r &&
    settle_cnt_r == pulse_setup_pkg::settle_ms(smooth_cfg_r) - 1'b1;
  assign ev[pulse_setup_pkg::EV_SERVO] = servo_nxt && !servo_r;

  // Sticky status, write one to clear; a new event wins over the clear
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      status_r <= '0;
    end
    else if (wr_stb && addr == pulse_setup_pkg::OFS_STATUS)
    begin
      status_r <= (status_r & ~wdata[EV_W-1:0]) | ev;
    end
    else
    begin
      status_r <= status_r | ev;
    end
  end

  // Interrupt mask
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mask_r <= '0;
    end
    else if (wr_stb && addr == pulse_setup_pkg::OFS_MASK)
    begin
      mask_r <= wdata[EV_W-1:0];
    end
  end

  // Interrupt level from flip-flop
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_r <= 1'b0;
    end
    else
    begin
      irq_r <= |((status_r | ev) & mask_r);
    end
  end

  // Read multiplexer; unmapped offsets read zero
  always_comb
  begin
    rdata_nxt = '0;
    unique case (addr)
      pulse_setup_pkg::OFS_CONFIG:
      begin
        rdata_nxt[3:0] = pulse_cfg_r;
        rdata_nxt[6:4] = smooth_cfg_r;
        rdata_nxt[8] = smooth_bad_r;
      end
      pulse_setup_pkg::OFS_RESOLUTION:
      begin
        rdata_nxt[13:0] = pulse_setup_pkg::resolution(
          pulse_cfg_r[pulse_setup_pkg::SEL_RES_LSB +: 2]);
      end
      pulse_setup_pkg::OFS_ACCEL:
      begin
        rdata_nxt[7:0] = pulse_setup_pkg::accel_ms(smooth_cfg_r);
      end
      pulse_setup_pkg::OFS_SETTLE:
      begin
        rdata_nxt[MS_W-1:0] =
          pulse_setup_pkg::settle_ms(smooth_cfg_r);
      end
      pulse_setup_pkg::OFS_STATUS:
      begin
        rdata_nxt[EV_W-1:0] = status_r;
      end
      pulse_setup_pkg::OFS_MASK:
      begin
        rdata_nxt[EV_W-1:0] = mask_r;
      end
      pulse_setup_pkg::OFS_STATE:
      begin
        rdata_nxt[0] = servo_r;
        rdata_nxt[1] = fault_out_r;
        rdata_nxt[2] = inpos_r;
        rdata_nxt[5:3] = fault_lamp_r;
        rdata_nxt[6] = run_armed_r;
      end
      pulse_setup_pkg::OFS_POSITION:
      begin
        rdata_nxt[POS_W-1:0] = pos_r;
      end
      default:
      begin
        rdata_nxt = '0;
      end
    endcase
  end

  // Read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rdata_r <= '0;
    end
    else if (rd_stb)
    begin
      rdata_r <= rdata_nxt;
    end
    else
    begin
      rdata_r <= '0;
    end
  end

  // Output drive
  assign rdata = rdata_r;
  assign fault_output = fault_out_r;
  assign indicator_orange = orange_r;
  assign indicator_green = green_r;
  assign fault_indicators = fault_lamp_r;
  assign servo_on = servo_r;
  assign fwd_step = fwd_r;
  assign rev_step = rev_r;
  assign in_position = inpos_r;
  assign irq = irq_r;

endmodule : pulse_command_input_setup
`default_nettype wire

//--- test/pulse_setup_asserts.sv
`timescale 1ns/10ps
`default_nettype none
// Ties panel outputs to their causes
module pulse_setup_asserts #(
  parameter int MS_CYCLES = 4,
  parameter int POWERUP_MS = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // Watched ports
  input wire logic run_cmd,
  input wire logic [2:0] fault_detect,
  input wire logic fault_output,
  input wire logic indicator_orange,
  input wire logic indicator_green,
  input wire logic [2:0] fault_indicators,
  input wire logic servo_on,
  input wire logic fwd_step,
  input wire logic rev_step
);
  logic [7:0] age_r;
  // Cycles since reset release, saturating
  always_ff @(posedge clk or negedge arst_n)
    if (!arst_n)
      age_r <= 8'h00;
    else if (age_r != 8'hff)
      age_r <= age_r + 8'h01;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  powerup_quiet_a: assert property (
    age_r != 8'hff && int'(age_r) < (POWERUP_MS - 1) * MS_CYCLES
    |-> !fault_output)
    else $error("fault output valid too early");
  lamp_excl_a: assert property (
    !(indicator_orange && indicator_green))
    else $error("both command lamp colours lit");
  run_green_a: assert property (
    $rose(run_cmd) && indicator_orange && $past(indicator_orange)
    && fault_detect == 3'h0 |=> indicator_green)
    else $error("run did not turn lamp green");
  green_servo_a: assert property (
    indicator_green |-> servo_on)
    else $error("green lamp without motor energised");
  step_off_a: assert property (
    !$past(servo_on) && !$past(servo_on, 2) |-> !(fwd_step || rev_step))
    else $error("step pulse while motor off");
  step_single_a: assert property (
    fwd_step || rev_step |=> !(fwd_step || rev_step))
    else $error("step pulse longer than one cycle");
  step_excl_a: assert property (
    !(fwd_step && rev_step))
    else $error("forward and reverse step together");
  fault_lamp_a: assert property (
    fault_output && fault_detect != 3'h0 |-> ##[1:3] fault_indicators != 3'h0)
    else $error("error did not light a fault lamp");
  alarm_out_a: assert property (
    fault_indicators != 3'h0 |=> !fault_output)
    else $error("fault output high with lamp lit");
  cover property ($rose(indicator_green));
  cover property (fwd_step);
  cover property (fault_indicators != 3'h0);
endmodule : pulse_setup_asserts
bind pulse_command_input_setup pulse_setup_asserts #(
  .MS_CYCLES(MS_CYCLES),
  .POWERUP_MS(POWERUP_MS)
) chk (.clk(clk), .arst_n(arst_n), .run_cmd(run_cmd),
  .fault_detect(fault_detect), .fault_output(fault_output),
  .indicator_orange(indicator_orange), .indicator_green(indicator_green),
  .fault_indicators(fault_indicators), .servo_on(servo_on),
  .fwd_step(fwd_step), .rev_step(rev_step));
`default_nettype wire

//--- test/host_pulse_model.sv
`timescale 1ns/10ps
`default_nettype none
// Host controller: run command and step commands on two pins
module host_pulse_model (
  // Clock
  input wire logic clk,
  // Lines toward the drive
  output var logic pin_a,
  output var logic pin_b,
  output var logic run_cmd
);
  // Run stays off from power-up until asked for
  initial
  begin
    pin_a = 1'b0;
    pin_b = 1'b0;
    run_cmd = 1'b0;
  end
  // Parks both pins at the inactive level
  task automatic idle(input logic lo);
    @(posedge clk);
    pin_a <= lo;
    pin_b <= lo;
  endtask : idle
  // Changes the run command after an edge
  task automatic run(input logic v);
    @(posedge clk);
    run_cmd <= v;
  endtask : run
  // Sends n steps; sd step plus direction, lo active low
  task automatic send(input logic sd, input logic lo, input logic fwd,
                      input int n);
    if (sd)
    begin
      @(posedge clk);
      pin_b <= fwd ? !lo : lo;
    end
    repeat (n)
    begin
      repeat (2) @(posedge clk);
      if (sd || fwd)
        pin_a <= !lo;
      else
        pin_b <= !lo;
      repeat (2) @(posedge clk);
      if (sd || fwd)
        pin_a <= lo;
      else
        pin_b <= lo;
    end
  endtask : send
endmodule : host_pulse_model
`default_nettype wire

//--- test/pulse_command_input_setup_tb.sv
`timescale 1ns/10ps
`default_nettype none
// Bench for the panel setup logic with a host on the pins
module pulse_command_input_setup_tb;
  localparam int MS = 4;
  localparam int PU = 3;
  logic clk, arst_n, pin_a, pin_b, run_cmd, wr_stb, rd_stb;
  logic [3:0] pulse_sel, smooth;
  logic [2:0] fault_detect, lamps;
  logic [7:0] addr;
  logic [31:0] wdata, rdata;
  logic fault_output, orange, green, servo_on, fwd_step, rev_step;
  logic in_position, irq;
  int n_fail = 0;
  int checks = 0;
  int n_fwd = 0;
  int n_rev = 0;
  int res_t[4] = '{1000, 2500, 5000, 10000};
  int acc_t[8] = '{45, 50, 60, 65, 70, 80, 85, 170};
  int set_t[8] = '{100, 110, 130, 150, 170, 200, 250, 500};
  // Clock
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  host_pulse_model HOST (.clk(clk), .pin_a(pin_a), .pin_b(pin_b),
    .run_cmd(run_cmd));
  pulse_command_input_setup #(.MS_CYCLES(MS), .POWERUP_MS(PU)) DUT (
    .clk(clk), .arst_n(arst_n), .pulse_sel(pulse_sel),
    .smoothing_selector(smooth), .forward_pulse_input(pin_a),
    .reverse_pulse_input(pin_b), .run_cmd(run_cmd),
    .fault_detect(fault_detect), .addr(addr), .wdata(wdata),
    .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .fault_output(fault_output), .indicator_orange(orange),
    .indicator_green(green), .fault_indicators(lamps),
    .servo_on(servo_on), .fwd_step(fwd_step), .rev_step(rev_step),
    .in_position(in_position), .irq(irq));
  // Counts step pulses
  always @(posedge clk)
  begin
    n_fwd += int'(fwd_step === 1'b1);
    n_rev += int'(rev_step === 1'b1);
  end
  task automatic test_done();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // Waits for a high level; gives up after lim cycles
  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim)
    begin
      @(negedge clk);
      n++;
    end
    if (s !== 1'b1)
    begin
      chk("wait", 32'h1, 32'h0);
      test_done();
    end
  endtask : wait_hi
  task automatic wr(logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr
  task automatic rd_chk(string nm, logic [7:0] a, logic [31:0] m,
                        logic [31:0] e);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    @(negedge clk);
    chk(nm, e, rdata & m);
  endtask : rd_chk
  task automatic power_up(logic [3:0] p, logic [3:0] s);
    int n;
    pulse_sel <= p;
    smooth <= s;
    arst_n <= 1'b0;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    wait_hi(fault_output, 100, n);
    chk("ready time", 1, n >= (PU - 1) * MS && n <= (PU + 1) * MS + 4);
    @(posedge clk);
    pulse_sel <= ~p;
    smooth <= ~s;
  endtask : power_up
  // One pulse format and smoothing step, steps both ways
  task automatic mode_case(int i);
    logic [3:0] p;
    int k;
    int n;
    p = 4'(i);
    k = p[3] ? 0 : int'(p[2:0]);
    HOST.idle(p[2]);
    power_up(p, p);
    rd_chk("config", 8'h00, 32'h0000_010f, {23'h0, p[3], 4'h0, p});
    rd_chk("resolution", 8'h04, 32'h0000_3fff, res_t[p[1:0]]);
    rd_chk("accel", 8'h08, 32'h0000_00ff, acc_t[k]);
    rd_chk("settle", 8'h0C, 32'h0000_07ff, set_t[k]);
    chk("orange", 1, orange);
    HOST.run(1'b1);
    wait_hi(green, 4, n);
    chk("servo on", 1, servo_on);
    n_fwd = 0;
    n_rev = 0;
    HOST.send(p[3], p[2], 1'b1, 3);
    HOST.send(p[3], p[2], 1'b0, 2);
    wait_hi(in_position, set_t[k] * MS + 40, n);
    chk("settle time", 1, n >= set_t[k] * MS - 8 && n <= set_t[k] * MS + 16);
    chk("forward steps", 3, n_fwd);
    chk("reverse steps", 2, n_rev);
    rd_chk("position", 8'h1C, 32'h0000_ffff, 32'h1);
    HOST.run(1'b0);
  endtask : mode_case
  // Fault lamp, fault output and interrupt masking and clearing
  task automatic fault_case();
    int n;
    HOST.idle(1'b0);
    power_up(4'h0, 4'h0);
    wr(8'h10, 32'h0000_000f);
    wr(8'h14, 32'h0000_0002);
    rd_chk("mask", 8'h14, 32'h0000_000f, 32'h2);
    chk("irq idle", 0, irq);
    @(posedge clk);
    fault_detect <= 3'b010;
    @(posedge clk);
    fault_detect <= 3'b000;
    wait_hi(irq, 6, n);
    @(negedge clk);
    chk("lamps", 3'b010, lamps);
    chk("fault output", 0, fault_output);
    wr(8'h14, 32'h0);
    repeat (2) @(negedge clk);
    chk("irq masked", 0, irq);
    wr(8'h14, 32'h0000_0002);
    wait_hi(irq, 4, n);
    wr(8'h10, 32'h0000_0002);
    repeat (2) @(negedge clk);
    chk("irq cleared", 0, irq);
    wr(8'h20, 32'h0000_0001);
    repeat (2) @(negedge clk);
    chk("lamps cleared", 3'b000, lamps);
    rd_chk("unmapped", 8'h40, 32'hffff_ffff, 32'h0);
  endtask : fault_case
  initial
  begin
    {arst_n, wr_stb, rd_stb, pulse_sel, smooth} = '0;
    {fault_detect, addr, wdata} = '0;
    for (int i = 0; i < 16; i++)
      mode_case(i);
    fault_case();
    test_done();
  end
endmodule : pulse_command_input_setup_tb
`default_nettype wire
